// ---- shared/dpa_pkg.sv ----
// Purpose: Constants and types for the shared RAM arbiter
// Assumes: 20-bit local address, 16-bit RAM words
// Notes:   Address limits are inclusive upper bounds
`default_nettype none
package dpa_pkg;
    localparam int unsigned     DPA_ADDR_W      = 20;
    localparam int unsigned     DPA_DATA_W      = 16;
    localparam logic [19:0]     DPA_BASE_TOP    = 20'h7FFFF;
    localparam logic [19:0]     DPA_EXP_TOP     = 20'h9FFFF;
    localparam logic [19:0]     DPA_BASE_START  = 20'h00000;
    typedef enum logic [1:0] {
        DPA_IDLE,
        DPA_LOCAL,
        DPA_REMOTE
    } dpa_state_t;
endpackage
`default_nettype wire

// ---- verilog/dpa_lane_swap.sv ----
// Purpose: Byte lane steering between system bus and 16-bit RAM word
// Assumes: Byte-wide masters use the low data lane only
// Notes:   Pure combinational; read data registered by the caller
`default_nettype none
module dpa_lane_swap
    import dpa_pkg::*;
(
    input  wire logic [15:0]    i_bus_wdata,
    input  wire logic           i_byte_xfer,
    input  wire logic           i_addr_odd,
    input  wire logic [15:0]    i_ram_rdata,
    output logic      [15:0]    o_ram_wdata,
    output logic      [1:0]     o_ram_be,
    output logic      [15:0]    o_bus_rdata
);
    always_comb begin
        if (!i_byte_xfer) begin
            o_ram_wdata = i_bus_wdata;
            o_ram_be    = 2'h3;
            o_bus_rdata = i_ram_rdata;
        end else if (i_addr_odd) begin
            // Odd byte moves from low lane to high lane
            o_ram_wdata = {i_bus_wdata[7:0], i_bus_wdata[7:0]};
            o_ram_be    = 2'h2;
            o_bus_rdata = {i_ram_rdata[15:8], i_ram_rdata[15:8]};
        end else begin
            o_ram_wdata = {i_bus_wdata[7:0], i_bus_wdata[7:0]};
            o_ram_be    = 2'h1;
            o_bus_rdata = {i_ram_rdata[7:0], i_ram_rdata[7:0]};
        end
    end
endmodule
`default_nettype wire

// ---- verilog/dpa_arbiter.sv ----
// Purpose: Shared RAM ownership arbiter, local processor vs system bus
// Assumes: All inputs synchronous except system bus control pins, synchronised here
// Notes:   Neither side owns the RAM while both sides are idle
//
// Functional notes
// - Idle leaves the RAM owned by neither side.
// - Remote request waits until local ownership ends.
// - Remote completion returns ownership to idle.
// - System bus transfers full words or single bytes.
// - Byte lanes steered for 8/16-bit masters.
// - Overlay inhibit suppresses RAM response.
// - Local lock holds ownership, refuses remote.
// - Remote lock holds ownership, blocks local.
// - Base decode maps zero to 7FFFFH.
// - Expansion decode maps zero to 9FFFFH.
// - Local request plus command grants locally if idle and remote is not requesting.
// - Remote match plus command enters slave mode if idle and not inhibited.
`default_nettype none
module dpa_arbiter
    import dpa_pkg::*;
(
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_rst_b,
    input  wire logic [DPA_ADDR_W-1:0]  i_loc_addr,
    input  wire logic                   i_loc_mem_cmd,
    input  wire logic                   i_loc_lock,
    input  wire logic                   i_exp_fitted,
    input  wire logic                   i_remote_address_match_request,
    input  wire logic                   i_remote_cmd,
    input  wire logic                   i_remote_lock,
    input  wire logic                   i_overlay_inhibit_n,
    input  wire logic                   i_remote_byte,
    input  wire logic                   i_remote_odd,
    input  wire logic [DPA_DATA_W-1:0]  i_remote_wdata,
    input  wire logic [DPA_DATA_W-1:0]  i_ram_rdata,
    output logic                        o_loc_ram_hit,
    output logic                        o_shared_ram_grant_n,
    output logic                        o_local_command_gate_n,
    output logic                        o_slave_command_gate_n,
    output logic [DPA_DATA_W-1:0]       o_ram_wdata,
    output logic [1:0]                  o_ram_be,
    output logic [DPA_DATA_W-1:0]       o_remote_rdata
);
    logic [3:0]                 sync1_r;
    logic [3:0]                 sync2_r;
    logic [3:0]                 sync1_nxt;
    logic [3:0]                 sync2_nxt;
    dpa_state_t                 state_r;
    dpa_state_t                 state_nxt;
    logic [DPA_DATA_W-1:0]      rdata_r;
    logic [DPA_DATA_W-1:0]      rdata_nxt;
    logic [DPA_DATA_W-1:0]      swap_rdata;
    logic                       rem_req;
    logic                       rem_lock;
    logic                       loc_req;

    // Remote pins: match, cmd, lock, inhibit through two flops
    always_comb begin
        sync1_nxt = {i_remote_address_match_request, i_remote_cmd,
                     i_remote_lock, ~i_overlay_inhibit_n};
        sync2_nxt = sync1_r;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
        end
    end

    // Address decode for local side
    always_comb begin
        if (i_exp_fitted) begin
            o_loc_ram_hit = (i_loc_addr >= DPA_BASE_START)
                            && (i_loc_addr <= DPA_EXP_TOP);
        end else begin
            o_loc_ram_hit = (i_loc_addr >= DPA_BASE_START)
                            && (i_loc_addr <= DPA_BASE_TOP);
        end
    end

    assign loc_req  = o_loc_ram_hit && i_loc_mem_cmd;
    // Inhibit masks remote requests entirely
    assign rem_req  = sync2_r[3] && sync2_r[2] && !sync2_r[0];
    assign rem_lock = sync2_r[1];

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            DPA_IDLE: begin
                if (rem_req) begin
                    state_nxt = DPA_REMOTE;
                end else if (loc_req) begin
                    state_nxt = DPA_LOCAL;
                end
            end
            DPA_LOCAL: begin
                if (!loc_req && !i_loc_lock) begin
                    state_nxt = DPA_IDLE;
                end
            end
            DPA_REMOTE: begin
                if (!rem_req && !rem_lock) begin
                    state_nxt = DPA_IDLE;
                end
            end
            default: begin
                state_nxt = DPA_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            state_r <= DPA_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Grants are exclusive by state
    always_comb begin
        o_shared_ram_grant_n   = (state_r == DPA_IDLE);
        o_local_command_gate_n = (state_r != DPA_LOCAL);
        o_slave_command_gate_n = (state_r != DPA_REMOTE);
    end

    dpa_lane_swap u_swap (
        .i_bus_wdata    (i_remote_wdata),
        .i_byte_xfer    (i_remote_byte),
        .i_addr_odd     (i_remote_odd),
        .i_ram_rdata    (i_ram_rdata),
        .o_ram_wdata    (o_ram_wdata),
        .o_ram_be       (o_ram_be),
        .o_bus_rdata    (swap_rdata)
    );

    // Remote read word captured while slave owns RAM
    always_comb begin
        rdata_nxt = rdata_r;
        if (state_r == DPA_REMOTE) begin
            rdata_nxt = swap_rdata;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign o_remote_rdata = rdata_r;

    chk_grant_exclusive: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !(!o_local_command_gate_n && !o_slave_command_gate_n))
        else $error("both sides granted");
    chk_remote_entry: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state_r == DPA_IDLE && rem_req) |=> !o_slave_command_gate_n)
        else $error("remote not granted from idle");
    chk_local_lock_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state_r == DPA_LOCAL && i_loc_lock) |=> !o_local_command_gate_n)
        else $error("local lock lost");
    chk_remote_lock_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state_r == DPA_REMOTE && rem_lock) |=> o_local_command_gate_n)
        else $error("remote lock lost");
    chk_remote_return: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state_r == DPA_REMOTE && !rem_req && !rem_lock) |=> state_r == DPA_IDLE)
        else $error("ownership not returned");
    chk_inhibit_block: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state_r == DPA_IDLE && sync2_r[0] && !loc_req) |=> o_shared_ram_grant_n)
        else $error("inhibited RAM responded");
    chk_local_entry: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state_r == DPA_IDLE && loc_req && !rem_req) |=> !o_local_command_gate_n)
        else $error("local not granted");
    chk_decode_range: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (!i_exp_fitted && i_loc_addr > DPA_BASE_TOP) |-> !o_loc_ram_hit)
        else $error("decode beyond base range");

    // Gate patterns of each ownership state, and the remote release transition
    sequence s_idle_gates;
        o_shared_ram_grant_n && o_local_command_gate_n && o_slave_command_gate_n;
    endsequence
    sequence s_local_owns;
        !o_shared_ram_grant_n && !o_local_command_gate_n && o_slave_command_gate_n;
    endsequence
    sequence s_remote_owns;
        !o_shared_ram_grant_n && o_local_command_gate_n && !o_slave_command_gate_n;
    endsequence
    sequence s_remote_release;
        !o_slave_command_gate_n ##1 o_slave_command_gate_n;
    endsequence

    chk_idle_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state_r == DPA_IDLE && !rem_req) |=> o_slave_command_gate_n)
        else $error("remote granted without request");
    chk_remote_handover: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        $fell(o_slave_command_gate_n) |-> $past(o_local_command_gate_n))
        else $error("remote granted while local owned");
    chk_remote_owns: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state_r == DPA_IDLE && rem_req) |=> s_remote_owns)
        else $error("remote ownership pattern wrong");
    chk_local_refuse: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state_r == DPA_LOCAL) |=> o_slave_command_gate_n)
        else $error("remote entered during local access");
    chk_local_owns: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state_r == DPA_IDLE && loc_req && !rem_req) |=> s_local_owns)
        else $error("local ownership pattern wrong");
    chk_return_idle: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state_r == DPA_REMOTE && !rem_req && !rem_lock) |=> s_idle_gates)
        else $error("gates not released after remote");
    chk_idle_between: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        s_remote_release |-> o_local_command_gate_n)
        else $error("local granted straight after remote");
    chk_word_capture: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state_r == DPA_REMOTE && !i_remote_byte) |=> (o_remote_rdata == $past(i_ram_rdata)))
        else $error("remote word read lost");
    chk_word_lanes: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !i_remote_byte |-> (o_ram_be == 2'h3 && o_ram_wdata == i_remote_wdata))
        else $error("word write lanes wrong");
    chk_odd_lane: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (i_remote_byte && i_remote_odd)
        |-> (o_ram_be == 2'h2 && o_ram_wdata[15:8] == i_remote_wdata[7:0]))
        else $error("odd byte lane wrong");
    chk_even_lane: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (i_remote_byte && !i_remote_odd)
        |-> (o_ram_be == 2'h1 && o_ram_wdata[7:0] == i_remote_wdata[7:0]))
        else $error("even byte lane wrong");
endmodule
`default_nettype wire

// ---- bench/dpa_far_model.sv ----
// Purpose: System bus master model for the shared RAM arbiter
// Assumes: One request at a time, held until the slave gate is seen low
// Notes:   Released write data shows the inverse of the last value
`default_nettype none
module dpa_far_model
    import dpa_pkg::*;
(
    input  wire logic           i_sys_clk,
    input  wire logic           i_go,
    input  wire logic           i_lk,
    input  wire logic           i_slave_gate_n,
    output logic                o_req,
    output logic                o_lk,
    output logic      [15:0]    o_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_req = 1'h0;
        o_lk = 1'h0;
        o_wdata = 16'h5AA5;
    end
    always @(posedge i_sys_clk) begin
        o_lk <= i_lk;
        if (i_go && !o_req) begin
            o_req <= 1'h1;
            o_wdata <= 16'hA55A;
        end else if (o_req && !i_slave_gate_n) begin
            o_req <= 1'h0;
            o_wdata <= ~o_wdata;
        end
    end
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// Purpose: Self-checking bench for the shared RAM arbiter
// Assumes: Remote inputs pass a two-flop synchroniser
// Notes:   Bench-driven inputs change 1 ns after the rising edge; far model outputs change on it
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import dpa_pkg::*;
    logic i_sys_clk = 0, i_rst_b = 0, cmd = 0, llk = 0, exf = 0, inh_n = 1;
    logic byt = 0, odd = 0, go = 0, rlk = 0, req, rlo, hit, gr_n, lg_n, sg_n;
    logic [19:0] addr = 0;
    logic [15:0] wd, rwd, rrd;
    logic [1:0] be;
    int n_mismatch = 0, n_tests = 0, cyc = 0;
    always #5 i_sys_clk = ~i_sys_clk;
    dpa_far_model FAR(.i_sys_clk(i_sys_clk), .i_go(go), .i_lk(rlk),
        .i_slave_gate_n(sg_n), .o_req(req), .o_lk(rlo), .o_wdata(wd));
    dpa_arbiter DUT(.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_loc_addr(addr),
        .i_loc_mem_cmd(cmd), .i_loc_lock(llk), .i_exp_fitted(exf),
        .i_remote_address_match_request(req), .i_remote_cmd(req),
        .i_remote_lock(rlo), .i_overlay_inhibit_n(inh_n), .i_remote_byte(byt),
        .i_remote_odd(odd), .i_remote_wdata(wd), .i_ram_rdata(16'h3C96),
        .o_loc_ram_hit(hit), .o_shared_ram_grant_n(gr_n),
        .o_local_command_gate_n(lg_n), .o_slave_command_gate_n(sg_n),
        .o_ram_wdata(rwd), .o_ram_be(be), .o_remote_rdata(rrd));
    task wrap_up;
        $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    task step(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wait_sg;
        for (int k = 0; k < 12 && sg_n !== 1'h0; k++) step(1);
    endtask
    task t_decode;
        logic [19:0] a[4] = '{20'h7FFFF, 20'h80000, 20'h9FFFF, 20'hA0000};
        for (int e = 0; e < 2; e++) begin
            exf = e[0];
            for (int i = 0; i < 4; i++) begin
                addr = a[i];
                step(1);
                chk(hit, a[i] <= (exf ? DPA_EXP_TOP : DPA_BASE_TOP));
            end
        end
        addr = 20'h00000;
        exf = 1'h0;
        $display("decode done");
    endtask
    task t_local;
        chk({gr_n, lg_n, sg_n}, 16'h0007);
        cmd = 1'h1;
        step(2);
        chk({gr_n, lg_n, sg_n}, 16'h0001);
        cmd = 1'h0;
        step(3);
        chk({gr_n, lg_n}, 16'h0003);
        $display("local done");
    endtask
    task t_remote(input logic lk, input logic ll, input logic ih);
        rlk = lk;
        llk = ll;
        cmd = ll;
        inh_n = ih;
        step(3);
        go = 1'h1;
        step(1);
        go = 1'h0;
        if (ll || !ih) begin
            step(10);
            chk(sg_n, 16'h0001);
            llk = 1'h0;
            cmd = 1'h0;
            inh_n = 1'h1;
        end
        wait_sg;
        chk({gr_n, lg_n, sg_n}, 16'h0002);
        for (int i = 0; i < 3; i++) begin
            byt = (i != 0);
            odd = (i == 2);
            step(1);
            chk(be, (i == 0) ? 2'h3 : i[1:0]);
            chk(rwd, byt ? {wd[7:0], wd[7:0]} : wd);
            chk(rrd, (i == 0) ? 16'h3C96 : ((i == 1) ? 16'h9696 : 16'h3C3C));
        end
        if (lk) begin
            cmd = 1'h1;
            step(8);
            chk({lg_n, sg_n}, 16'h0002);
            rlk = 1'h0;
            step(8);
            chk(lg_n, 16'h0000);
            cmd = 1'h0;
        end
        step(8);
        chk({gr_n, lg_n, sg_n}, 16'h0007);
        $display("remote done");
    endtask
    initial begin
        step(20);
        i_rst_b = 1'h1;
        step(3);
        t_decode();
        t_local();
        t_remote(1'h0, 1'h0, 1'h1);
        t_remote(1'h0, 1'h1, 1'h1);
        t_remote(1'h0, 1'h0, 1'h0);
        t_remote(1'h1, 1'h0, 1'h1);
        wrap_up();
    end
endmodule
`default_nettype wire
